// ==== control_model.sv ====
// machine control model driving the gating switch and timer hold lines
// assumes the bench calls its tasks; lines change right after a rising edge
`timescale 1ns/1ps
module control_model (
   input wire logic clk,
   output logic sw,
   output logic hold
);
   // hold is its own register, idle opposite to the switch
   initial begin
      sw = 1'b0;
      hold = 1'b1;
   end

   // switch rises, hold falls gap cycles later
   task automatic start_pair(input int gap);
      @(posedge clk);
      sw <= 1'b1;
      repeat (gap) @(posedge clk);
      hold <= 1'b0;
   endtask : start_pair

   // faulty control: switch rises, hold never follows
   task automatic lone_rise();
      @(posedge clk);
      sw <= 1'b1;
   endtask : lone_rise

   // hold rise while gating extends the timeout
   task automatic extend();
      @(posedge clk);
      hold <= 1'b1;
   endtask : extend

   // controlled end: switch falls, hold rises opposite
   task automatic stop_pair();
      @(posedge clk);
      sw <= 1'b0;
      hold <= 1'b1;
   endtask : stop_pair
endmodule : control_model

// ==== conveyor_gating_sequencer.sv ====
// gating sequencer of a light curtain receiver with an AHB-Lite register slave
// assumes the gating, sensor and button pins asynchronous to CLK_SYS; one AHB-Lite master on the bus
//
// Design decisions made here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "gating_defines.svh"

module conveyor_gating_sequencer
   import gating_pkg::*;
#(
   parameter logic [47:0] PAIR_CYC = `PAIR_CYC,
   parameter logic [47:0] ARM_CYC = `ARM_CYC,
   parameter logic [47:0] GATE_CYC = `GATE_CYC,
   parameter logic [47:0] EXT_CYC = `EXT_CYC,
   parameter logic [47:0] SYNC_CYC = `SYNC_CYC,
   parameter logic [47:0] PROT_CYC = `PROT_CYC,
   parameter logic [47:0] PRESS_MIN_CYC = `PRESS_MIN_CYC,
   parameter logic [47:0] PRESS_MAX_CYC = `PRESS_MAX_CYC,
   parameter logic [47:0] OVR_CYC = `OVR_CYC,
   parameter logic [47:0] OVR_LOCK_CYC = `OVR_LOCK_CYC,
   parameter logic [47:0] FILT_LONG_CYC = `FILT_LONG_CYC,
   parameter logic [47:0] FILT_SHORT_CYC = `FILT_SHORT_CYC,
   parameter logic [47:0] FILT_STD_CYC = `FILT_STD_CYC,
   parameter logic [47:0] LAMP_CYC = `LAMP_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic GATING_SWITCH,
   input wire logic TIMER_HOLD_SIGNAL,
   input wire logic FIELD_INTERRUPTED,
   input wire logic UPPER_BEAMS_INTERRUPTED,
   input wire logic SYNC_TOP_INTERRUPTED,
   input wire logic SYNC_BOTTOM_INTERRUPTED,
   input wire logic RESTART_BUTTON,
   output logic SAFETY_OUTPUT,
   output logic GATING_LAMP_OUTPUT,
   output logic GATING_ACTIVE
);

   // pin synchronisers and previous samples
   logic [6:0] meta_r, pin_r, prev_r;
   logic sw, hold, field, upper, sync_both, button;
   logic sw_rise, sw_fall, hold_rise, hold_fall, btn_fall;
   // sequencer state
   state_t state_r, state_nxt;
   mode_t mode_r;
   logic released_r, released_nxt, ext_r, ext_nxt, pend_r, pend_nxt;
   logic ovr_arm_r, ovr_arm_nxt, safety_r, safety_nxt, lamp_r, lamp_nxt;
   logic [7:0] err_r, err_nxt;
   logic blink_r, gating_r;
   // timers
   logic [47:0] st_cnt_r, gate_cnt_r, sync_cnt_r, clear_cnt_r, press_cnt_r, lamp_cnt_r;
   // bus slave
   logic wr_pend_r, hreadyout_r, hresp_r, addr_ok;
   logic [7:0] wr_addr_r;
   logic [31:0] hrdata_r;
   logic start_pair, press_ok, sync_lost, timed_out;
   logic restart_need, override_need, valid_gating, upper_cut;

   function automatic logic need_hold(input mode_t m);
      return (m == MODE_QSTOP) || (m == MODE_PARTIAL);
   endfunction : need_hold
   function automatic logic [47:0] filter_cyc(input mode_t m);
      case (m)
         MODE_SHORT: filter_cyc = FILT_SHORT_CYC;
         MODE_STD: filter_cyc = FILT_STD_CYC;
         default: filter_cyc = FILT_LONG_CYC;
      endcase
   endfunction : filter_cyc
   // two-stage sampling, edges from consecutive samples
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         meta_r <= 7'h00;
         pin_r <= 7'h00;
         prev_r <= 7'h00;
      end else begin
         meta_r <= {RESTART_BUTTON, SYNC_BOTTOM_INTERRUPTED, SYNC_TOP_INTERRUPTED,
                    UPPER_BEAMS_INTERRUPTED, FIELD_INTERRUPTED, TIMER_HOLD_SIGNAL, GATING_SWITCH};
         pin_r <= meta_r;
         prev_r <= pin_r;
      end
   end

   assign sw = pin_r[0];
   assign hold = pin_r[1];
   assign field = pin_r[2];
   assign upper = pin_r[3];
   assign sync_both = pin_r[4] & pin_r[5];
   assign button = pin_r[6];
   assign sw_rise = pin_r[0] & ~prev_r[0];
   assign sw_fall = ~pin_r[0] & prev_r[0];
   assign hold_rise = pin_r[1] & ~prev_r[1];
   assign hold_fall = ~pin_r[1] & prev_r[1];
   assign btn_fall = ~pin_r[6] & prev_r[6];

   assign start_pair = sw_rise & (hold_fall | ~need_hold(mode_r));
   assign press_ok = btn_fall && (press_cnt_r >= PRESS_MIN_CYC)
                     && (press_cnt_r <= PRESS_MAX_CYC);
   assign sync_lost = sync_cnt_r >= SYNC_CYC;
   assign timed_out = gate_cnt_r >= (ext_r ? EXT_CYC : GATE_CYC);
   assign restart_need = field & ~sync_both & sw;
   assign override_need = field & sync_both & sw;
   assign valid_gating = field & sw;
   assign upper_cut = (mode_r == MODE_PARTIAL) & upper;

   // next state of the sequencer
   always_comb begin
      state_nxt = state_r;
      released_nxt = released_r;
      err_nxt = err_r;
      ext_nxt = ext_r;
      pend_nxt = pend_r;
      ovr_arm_nxt = ovr_arm_r;
      case (state_r)
         ST_IDLE: begin
            ext_nxt = 1'b0;
            if (field) released_nxt = 1'b0;
            if (!override_need) ovr_arm_nxt = 1'b0;
            if (start_pair) begin
               state_nxt = ST_ARMED;
            end else if (need_hold(mode_r) && (sw_rise || hold_fall)) begin
               state_nxt = ST_PAIR;
               pend_nxt = sw_rise;
            end else if (press_ok) begin
               if (!field) begin
                  released_nxt = 1'b1;
                  err_nxt = `ERR_NONE;
               end else if (restart_need) begin
                  state_nxt = ST_GATING;
                  released_nxt = 1'b1;
                  err_nxt = `ERR_NONE;
               end else if (override_need) begin
                  ovr_arm_nxt = 1'b1;
               end
            end else if (ovr_arm_r && override_need && button) begin
               state_nxt = ST_OVERRIDE;
               ovr_arm_nxt = 1'b0;
            end
         end
         ST_PAIR: begin
            if (field) released_nxt = 1'b0;
            if (pend_r ? hold_fall : sw_rise) begin
               state_nxt = ST_ARMED;
            end else if ((pend_r ? sw_fall : hold_rise) || (st_cnt_r >= PAIR_CYC)) begin
               state_nxt = ST_INTERLOCK;
               err_nxt = `ERR_SEQ;
            end
         end
         ST_ARMED: begin
            if (hold_rise) ext_nxt = 1'b1;
            if (sw_fall) begin
               state_nxt = ST_IDLE;
            end else if (field) begin
               state_nxt = ST_GATING;
            end else if (st_cnt_r >= ARM_CYC) begin
               state_nxt = ST_PROTECT;
               released_nxt = 1'b0;
            end
         end
         ST_GATING: begin
            if (hold_rise) ext_nxt = 1'b1;
            if (sw_fall) begin
               state_nxt = ST_IDLE;
            end else if (clear_cnt_r >= filter_cyc(mode_r)) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_PROTECT: begin
            released_nxt = 1'b0;
            if (press_ok && !field) begin
               state_nxt = ST_ARMED;
               released_nxt = 1'b1;
            end else if (sw_fall || field) begin
               state_nxt = ST_IDLE;
            end else if (st_cnt_r >= PROT_CYC) begin
               state_nxt = ST_INTERLOCK;
            end
         end
         ST_OVERRIDE: begin
            if (st_cnt_r >= OVR_LOCK_CYC) begin
               state_nxt = ST_INTERLOCK;
               released_nxt = 1'b0;
            end else if (!button) begin
               if (valid_gating && st_cnt_r < OVR_CYC) begin
                  state_nxt = ST_GATING;
                  released_nxt = 1'b1;
               end else begin
                  state_nxt = ST_IDLE;
                  released_nxt = 1'b0;
               end
            end
         end
         ST_INTERLOCK: begin
            released_nxt = 1'b0;
            if (press_ok) begin
               state_nxt = ST_IDLE;
               err_nxt = `ERR_NONE;
            end
         end
         default: begin
            state_nxt = ST_INTERLOCK;
            released_nxt = 1'b0;
         end
      endcase
      if (upper_cut) released_nxt = 1'b0;
      if ((state_r == ST_ARMED) || (state_r == ST_GATING)) begin
         if (upper_cut) begin
            state_nxt = ST_IDLE;
            released_nxt = 1'b0;
         end else if (timed_out) begin
            state_nxt = ST_IDLE;
            released_nxt = 1'b0;
            err_nxt = `ERR_TIMEOUT;
         end
      end
      if (sync_lost && (state_r != ST_OVERRIDE)) begin
         released_nxt = 1'b0;
         if ((state_r == ST_ARMED) || (state_r == ST_GATING)) begin
            state_nxt = ST_IDLE;
         end
      end
   end

   // outputs of the sequencer
   always_comb begin
      case (state_nxt)
         ST_IDLE, ST_PAIR: safety_nxt = released_nxt & ~field;
         ST_ARMED, ST_GATING: safety_nxt = released_nxt;
         ST_OVERRIDE: safety_nxt = button & (st_cnt_r < OVR_CYC);
         default: safety_nxt = 1'b0;
      endcase
      if (upper_cut) safety_nxt = 1'b0;
      case (state_nxt)
         ST_ARMED, ST_GATING: lamp_nxt = 1'b1;
         ST_PROTECT: lamp_nxt = blink_r;
         ST_IDLE: lamp_nxt = blink_r & ~released_nxt & restart_need;
         default: lamp_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         state_r <= ST_IDLE;
         released_r <= 1'b0;
         err_r <= `ERR_NONE;
         ext_r <= 1'b0;
         pend_r <= 1'b0;
         ovr_arm_r <= 1'b0;
         safety_r <= 1'b0;
         lamp_r <= 1'b0;
         gating_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         released_r <= released_nxt;
         err_r <= err_nxt;
         ext_r <= ext_nxt;
         pend_r <= pend_nxt;
         ovr_arm_r <= ovr_arm_nxt;
         safety_r <= safety_nxt;
         lamp_r <= lamp_nxt;
         gating_r <= (state_nxt == ST_ARMED) || (state_nxt == ST_GATING);
      end
   end

   // time in the present state
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || (state_nxt != state_r)) begin
         st_cnt_r <= 48'h0;
      end else if (st_cnt_r != 48'hFFFFFFFFFFFF) begin
         st_cnt_r <= st_cnt_r + 48'h1;
      end
   end

   // bridging time since the sequence started
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || ((state_r != ST_ARMED) && (state_r != ST_GATING))) begin
         gate_cnt_r <= 48'h0;
      end else if (!timed_out) begin
         gate_cnt_r <= gate_cnt_r + 48'h1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || !sync_both) begin
         sync_cnt_r <= 48'h0;
      end else if (!sync_lost) begin
         sync_cnt_r <= sync_cnt_r + 48'h1;
      end
   end

   // field clear time while gating
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || field || (state_r != ST_GATING)) begin
         clear_cnt_r <= 48'h0;
      end else begin
         clear_cnt_r <= clear_cnt_r + 48'h1;
      end
   end

   // press duration of the restart button
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || (!button && !btn_fall)) begin
         press_cnt_r <= 48'h0;
      end else if (button && (press_cnt_r <= PRESS_MAX_CYC)) begin
         press_cnt_r <= press_cnt_r + 48'h1;
      end
   end

   // lamp blink rate
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         lamp_cnt_r <= 48'h0;
         blink_r <= 1'b0;
      end else if (lamp_cnt_r >= LAMP_CYC - 48'h1) begin
         lamp_cnt_r <= 48'h0;
         blink_r <= ~blink_r;
      end else begin
         lamp_cnt_r <= lamp_cnt_r + 48'h1;
      end
   end

   // AHB-Lite slave, zero wait states
   assign addr_ok = HSEL & HTRANS[1] & HREADY;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata_r <= 32'h00000000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok & HWRITE;
         wr_addr_r <= HADDR[7:0];
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
         hrdata_r <= 32'h00000000;
         if (addr_ok && !HWRITE && (HADDR[7:0] == `OFS_CTRL)) begin
            hrdata_r <= {29'h0, mode_r};
         end else if (addr_ok && !HWRITE && (HADDR[7:0] == `OFS_STATUS)) begin
            hrdata_r <= {16'h0, err_r, 1'b0, ext_r, lamp_r, safety_r, state_r};
         end
      end
   end

   // operating mode, only documented modes are taken
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         mode_r <= mode_t'(`MODE_RST);
      end else if (wr_pend_r && (wr_addr_r == `OFS_CTRL)) begin
         case (HWDATA[2:0])
            MODE_QSTOP, MODE_SHORT, MODE_STD, MODE_PARTIAL: mode_r <= mode_t'(HWDATA[2:0]);
            default: mode_r <= mode_r;
         endcase
      end
   end

   assign HRDATA = hrdata_r;
   assign HREADYOUT = hreadyout_r;
   assign HRESP = hresp_r;
   assign SAFETY_OUTPUT = safety_r;
   assign GATING_LAMP_OUTPUT = lamp_r;
   assign GATING_ACTIVE = gating_r;

endmodule : conveyor_gating_sequencer

// ==== gating_checker.sv ====
// pin-level assertions of the gating sequencer, bound to its top module
// assumes the reset values of the design; mode is followed from bus writes
`timescale 1ns/1ps
module gating_checker
   import gating_pkg::*;
#(
   parameter logic [47:0] ARM_CYC = 48'h64,
   parameter logic [47:0] GATE_CYC = 48'h190,
   parameter logic [47:0] EXT_CYC = 48'h320,
   parameter logic [47:0] SYNC_CYC = 48'h12C
) (
   input wire logic CLK_SYS,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic GATING_SWITCH,
   input wire logic TIMER_HOLD_SIGNAL,
   input wire logic FIELD_INTERRUPTED,
   input wire logic UPPER_BEAMS_INTERRUPTED,
   input wire logic SYNC_TOP_INTERRUPTED,
   input wire logic SYNC_BOTTOM_INTERRUPTED,
   input wire logic RESTART_BUTTON,
   input wire logic SAFETY_OUTPUT,
   input wire logic GATING_ACTIVE
);
   logic wr_q;
   logic [2:0] mode_q;
   logic [47:0] arm_cnt;
   logic [47:0] act_cnt;
   logic [47:0] sync_cnt;
   logic [3:0] btn_age;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_B);

   // operating mode as written over the bus
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B) begin
         wr_q <= 1'b0;
         mode_q <= 3'h5;
      end else begin
         wr_q <= HSEL && HTRANS[1] && HREADY && HWRITE && (HADDR[7:0] == 8'h00);
         if (wr_q && (HWDATA[2:0] inside {3'h1, 3'h4, 3'h5, 3'h6})) begin
            mode_q <= HWDATA[2:0];
         end
      end
   end

   // gating active with the field clear
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || !GATING_ACTIVE || FIELD_INTERRUPTED) arm_cnt <= 48'h0;
      else arm_cnt <= arm_cnt + 48'h1;
   end

   // length of one gating sequence
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || !GATING_ACTIVE) act_cnt <= 48'h0;
      else act_cnt <= act_cnt + 48'h1;
   end

   // both sync beams cut with the button released
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || RESTART_BUTTON || !(SYNC_TOP_INTERRUPTED && SYNC_BOTTOM_INTERRUPTED)) begin
         sync_cnt <= 48'h0;
      end else begin
         sync_cnt <= sync_cnt + 48'h1;
      end
   end

   // cycles since the button was last pressed
   always_ff @(posedge CLK_SYS) begin
      if (!RST_B || RESTART_BUTTON) btn_age <= 4'h0;
      else if (btn_age != 4'hF) btn_age <= btn_age + 4'h1;
   end

   AST_UPPER_BEAMS: assert property (
      ((mode_q == MODE_PARTIAL) && UPPER_BEAMS_INTERRUPTED) [*6]
      |-> !GATING_ACTIVE && !SAFETY_OUTPUT)
      else $error("gating stays active with upper beams cut in partial mode");
   AST_PAIR_START: assert property (
      ((mode_q == MODE_QSTOP) || (mode_q == MODE_PARTIAL)) && $rose(GATING_ACTIVE)
      |-> !$past(TIMER_HOLD_SIGNAL, 3))
      else $error("gating started without the hold signal falling");
   AST_INPUT_LAG: assert property (
      $rose(GATING_ACTIVE) |-> $past(GATING_SWITCH, 3))
      else $error("gating active rose before the sampled switch");
   AST_SWITCH_END: assert property (
      !GATING_SWITCH [*6] |-> !GATING_ACTIVE)
      else $error("gating still active after switch removal");
   AST_ARM_LIMIT: assert property (arm_cnt <= ARM_CYC + 48'h8)
      else $error("gating active too long without field interruption");
   AST_GATE_LIMIT: assert property (act_cnt <= GATE_CYC + EXT_CYC + 48'h8)
      else $error("gating sequence longer than the extended timeout");
   AST_SYNC_LOSS: assert property (
      sync_cnt > SYNC_CYC + 48'h8 |-> !SAFETY_OUTPUT)
      else $error("safety output on after long sync beam loss");
   AST_SAFETY_CAUSE: assert property ($rose(SAFETY_OUTPUT) |-> btn_age < 4'h8)
      else $error("safety output switched on without a button action");

   cover property ($rose(GATING_ACTIVE));
   cover property ($fell(SAFETY_OUTPUT));
   cover property (RESTART_BUTTON && SAFETY_OUTPUT);
endmodule : gating_checker

bind conveyor_gating_sequencer gating_checker #(.ARM_CYC(ARM_CYC), .GATE_CYC(GATE_CYC),
   .EXT_CYC(EXT_CYC), .SYNC_CYC(SYNC_CYC)) gating_checker_i (
   .CLK_SYS(CLK_SYS), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
   .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .GATING_SWITCH(GATING_SWITCH),
   .TIMER_HOLD_SIGNAL(TIMER_HOLD_SIGNAL), .FIELD_INTERRUPTED(FIELD_INTERRUPTED),
   .UPPER_BEAMS_INTERRUPTED(UPPER_BEAMS_INTERRUPTED),
   .SYNC_TOP_INTERRUPTED(SYNC_TOP_INTERRUPTED), .SYNC_BOTTOM_INTERRUPTED(SYNC_BOTTOM_INTERRUPTED),
   .RESTART_BUTTON(RESTART_BUTTON), .SAFETY_OUTPUT(SAFETY_OUTPUT), .GATING_ACTIVE(GATING_ACTIVE));

// ==== gating_defines.svh ====
// offsets, field positions, reset values and timing figures of the gating sequencer
// assumes a 50 MHz system clock; counts are 48-bit cycle figures
`ifndef GATING_DEFINES_SVH
`define GATING_DEFINES_SVH

`define CLK_KHZ 48'hC350
`define MS_PER_S 48'h3E8
`define MS_PER_MIN 48'hEA60
`define MS_PER_H 48'h36EE80

`define T_PAIR_MS 48'h1F4
`define T_ARM_MS 48'hFA0
`define T_GATE_MIN 48'hA
`define T_EXT_H 48'h64
`define T_SYNC_S 48'h3C
`define T_PROT_H 48'h1
`define T_PRESS_MIN_MS 48'h96
`define T_PRESS_MAX_MS 48'hFA0
`define T_OVR_S 48'h78
`define T_OVR_LOCK_S 48'h96
`define T_FILT_LONG_MS 48'h7D0
`define T_FILT_SHORT_MS 48'h1F4
`define T_FILT_STD_MS 48'h3E8
`define T_LAMP_MS 48'h1F4

`define PAIR_CYC (`T_PAIR_MS * `CLK_KHZ)
`define ARM_CYC (`T_ARM_MS * `CLK_KHZ)
`define GATE_CYC (`T_GATE_MIN * `MS_PER_MIN * `CLK_KHZ)
`define EXT_CYC (`T_EXT_H * `MS_PER_H * `CLK_KHZ)
`define SYNC_CYC (`T_SYNC_S * `MS_PER_S * `CLK_KHZ)
`define PROT_CYC (`T_PROT_H * `MS_PER_H * `CLK_KHZ)
`define PRESS_MIN_CYC (`T_PRESS_MIN_MS * `CLK_KHZ)
`define PRESS_MAX_CYC (`T_PRESS_MAX_MS * `CLK_KHZ)
`define OVR_CYC (`T_OVR_S * `MS_PER_S * `CLK_KHZ)
`define OVR_LOCK_CYC (`T_OVR_LOCK_S * `MS_PER_S * `CLK_KHZ)
`define FILT_LONG_CYC (`T_FILT_LONG_MS * `CLK_KHZ)
`define FILT_SHORT_CYC (`T_FILT_SHORT_MS * `CLK_KHZ)
`define FILT_STD_CYC (`T_FILT_STD_MS * `CLK_KHZ)
`define LAMP_CYC (`T_LAMP_MS * `CLK_KHZ)

`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define CTRL_MODE_LSB 0
`define STAT_STATE_LSB 0
`define STAT_SAFETY_BIT 4
`define STAT_LAMP_BIT 5
`define STAT_EXT_BIT 6
`define STAT_ERR_LSB 8
`define MODE_RST 3'h5
`define ERR_NONE 8'h00
`define ERR_SEQ 8'h45
`define ERR_TIMEOUT 8'h4F

`endif

// ==== gating_pkg.sv ====
// types of the gating sequencer
// no surroundings assumed
package gating_pkg;
   typedef enum logic [2:0] {
      MODE_QSTOP = 3'h1,
      MODE_SHORT = 3'h4,
      MODE_STD = 3'h5,
      MODE_PARTIAL = 3'h6
   } mode_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_PAIR = 4'h1,
      ST_ARMED = 4'h3,
      ST_GATING = 4'h2,
      ST_PROTECT = 4'h6,
      ST_OVERRIDE = 4'h4,
      ST_INTERLOCK = 4'hC
   } state_t;
endpackage : gating_pkg

// ==== tb.sv ====
// self-checking bench of the gating sequencer: bus and pin tasks, scenarios
// assumes control_model and the bound checker are compiled alongside
`timescale 1ns/1ps
module tb;
   import gating_pkg::*;
   localparam logic [47:0] PAIR = 48'h14;
   localparam logic [47:0] ARM = 48'h64;
   localparam logic [47:0] GATE = 48'h190;
   localparam logic [47:0] SYNC = 48'h12C;
   localparam logic [47:0] PROT = 48'h1F4;
   localparam logic [47:0] EXT = 48'h320, PMIN = 48'h5, PMAX = 48'h32, OVR = 48'hC8;
   localparam logic [47:0] OLOCK = 48'hFA, FLONG = 48'h28, FSHORT = 48'hA, FSTD = 48'h14;
   localparam logic [47:0] LAMPC = 48'h4;
   logic clk, rst_b, hsel, hwrite, field, upper, sync_t, sync_b, button;
   logic [31:0] haddr, hwdata, rd, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, hresp, sw, hold, safety, lamp, active;
   int n_fail = 0;
   int compares = 0;
   int cycles = 0;

   control_model control_model_i (.clk(clk), .sw(sw), .hold(hold));
   conveyor_gating_sequencer #(
      .PAIR_CYC(PAIR), .ARM_CYC(ARM), .GATE_CYC(GATE), .EXT_CYC(EXT), .SYNC_CYC(SYNC),
      .PROT_CYC(PROT), .PRESS_MIN_CYC(PMIN), .PRESS_MAX_CYC(PMAX), .OVR_CYC(OVR),
      .OVR_LOCK_CYC(OLOCK), .FILT_LONG_CYC(FLONG), .FILT_SHORT_CYC(FSHORT),
      .FILT_STD_CYC(FSTD), .LAMP_CYC(LAMPC)
   ) conveyor_gating_sequencer_i (
      .CLK_SYS(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .GATING_SWITCH(sw), .TIMER_HOLD_SIGNAL(hold),
      .FIELD_INTERRUPTED(field), .UPPER_BEAMS_INTERRUPTED(upper), .SYNC_TOP_INTERRUPTED(sync_t),
      .SYNC_BOTTOM_INTERRUPTED(sync_b), .RESTART_BUTTON(button), .SAFETY_OUTPUT(safety),
      .GATING_LAMP_OUTPUT(lamp), .GATING_ACTIVE(active)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic report_and_stop();
      if (n_fail == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop

   // a hang ends the run as a mismatch
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles > 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %0h, expected %0h", $time, seen, exp);
      end
   endtask : chk

   // one single word transfer; read data taken at the end of the data phase
   task automatic bus(input logic [31:0] addr, input logic wr, input logic [31:0] wdata);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      do @(posedge clk); while (!hreadyout);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge clk); while (!hreadyout);
      rd = hrdata;
   endtask : bus

   task automatic status(input logic [3:0] st);
      bus(32'h4, 1'b0, 32'h0);
      chk(32'(rd[3:0]), 32'(st));
   endtask : status

   task automatic pins(input logic s, input logic a);
      repeat (6) @(posedge clk);
      chk({30'h0, safety, active}, {30'h0, s, a});
   endtask : pins

   task automatic press(input int n);
      @(posedge clk);
      button <= 1'b1;
      repeat (n) @(posedge clk);
      button <= 1'b0;
   endtask : press

   initial begin
      rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      field = 1'b0;
      upper = 1'b0;
      sync_t = 1'b0;
      sync_b = 1'b0;
      button = 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, refused mode, unmapped word
      bus(32'h0, 1'b0, 32'h0);
      chk(rd, 32'h5);
      bus(32'h0, 1'b1, 32'h2);
      bus(32'h0, 1'b0, 32'h0);
      chk(rd, 32'h5);
      bus(32'h8, 1'b0, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      status(ST_IDLE);
      // press too short, too long, then valid
      press(2);
      pins(1'b0, 1'b0);
      press(60);
      pins(1'b0, 1'b0);
      press(10);
      pins(1'b1, 1'b0);
      // standard mode: start, field cut, extension, controlled end
      control_model_i.start_pair(0);
      pins(1'b1, 1'b1);
      status(ST_ARMED);
      field <= 1'b1;
      pins(1'b1, 1'b1);
      control_model_i.extend();
      pins(1'b1, 1'b1);
      status(ST_GATING);
      chk(32'(rd[6]), 32'h1);
      field <= 1'b0;
      control_model_i.stop_pair();
      repeat (5) @(posedge clk);
      chk({31'h0, active}, 32'h0);
      // timeout with the field cut, then gating restart
      control_model_i.start_pair(0);
      field <= 1'b1;
      repeat (GATE + 10) @(posedge clk);
      pins(1'b0, 1'b0);
      status(ST_IDLE);
      chk(32'(rd[15:8]), 32'h4F);
      rd = {31'h0, lamp};
      repeat (4) @(posedge clk);
      chk({31'h0, lamp}, rd ^ 32'h1);
      press(10);
      pins(1'b1, 1'b1);
      status(ST_GATING);
      chk({31'h0, lamp}, 32'h1);
      // timeout again, both sync beams cut, override
      repeat (GATE + 10) @(posedge clk);
      pins(1'b0, 1'b0);
      sync_t <= 1'b1;
      sync_b <= 1'b1;
      press(10);
      pins(1'b0, 1'b0);
      @(posedge clk);
      button <= 1'b1;
      repeat (20) @(posedge clk);
      chk({31'h0, safety}, 32'h1);
      button <= 1'b0;
      pins(1'b1, 1'b1);
      repeat (SYNC + 10) @(posedge clk);
      chk({31'h0, safety}, 32'h0);
      sync_t <= 1'b0;
      sync_b <= 1'b0;
      field <= 1'b0;
      control_model_i.stop_pair();
      // no field interruption: protective mode, new sequence, interlock
      press(10);
      pins(1'b1, 1'b0);
      control_model_i.start_pair(0);
      repeat (ARM + 10) @(posedge clk);
      pins(1'b0, 1'b0);
      status(ST_PROTECT);
      press(10);
      repeat (6) @(posedge clk);
      chk({31'h0, active}, 32'h1);
      repeat (ARM + PROT + 20) @(posedge clk);
      status(ST_INTERLOCK);
      press(10);
      repeat (6) @(posedge clk);
      status(ST_IDLE);
      control_model_i.stop_pair();
      // partial mode: upper beams end gating
      bus(32'h0, 1'b1, 32'h6);
      press(10);
      pins(1'b1, 1'b0);
      control_model_i.start_pair(3);
      pins(1'b1, 1'b1);
      field <= 1'b1;
      upper <= 1'b1;
      pins(1'b0, 1'b0);
      upper <= 1'b0;
      field <= 1'b0;
      control_model_i.stop_pair();
      // qualified stop mode: lone switch rise is a faulty sequence
      bus(32'h0, 1'b1, 32'h1);
      control_model_i.lone_rise();
      repeat (PAIR + 10) @(posedge clk);
      status(ST_INTERLOCK);
      chk(32'(rd[15:8]), 32'h45);
      control_model_i.stop_pair();
      press(10);
      repeat (6) @(posedge clk);
      status(ST_IDLE);
      chk(32'(rd[15:8]), 32'h0);
      // short mode: switch alone starts, a clear field ends after the filter time
      bus(32'h0, 1'b1, 32'h4);
      control_model_i.lone_rise();
      field <= 1'b1;
      pins(1'b0, 1'b1);
      field <= 1'b0;
      repeat (FSHORT + 6) @(posedge clk);
      chk({31'h0, active}, 32'h0);
      report_and_stop();
   end
endmodule : tb
